// [src/enc_counter_map.svh]
// Register offsets, field positions, reset values and timing counts of the encoder counter.
// Assumes a 40 MHz aclk and an AXI4-Lite master that issues one aligned 32-bit word per access.
//
// Operation
// - Tracks A and B are decoded in quadrature into a 32-bit position counter that can be switched to 16 bits.
// - With the latch enabled and gating off, a rising gate/latch edge copies the position counter into a 32-bit latch register readable by the host.
// - The gate/latch input leaves counting alone, or freezes counting while it is high, or while it is low.
// - In single-channel mode only rising edges of track A count, and the level of track B sets up or down.
// - The time between rising edges of track A is measured in 100 ns units.
// - The longest measurable period is 1.6 s or 3.2 s, chosen by a range setting.
// - In frame-triggered mode a cycle starts when a frame arrival is signalled, with no local time base.
// - In clock-synchronous mode the local time base starts a cycle at fixed intervals aligned with output nodes.
// - In input-aligned synchronous mode the local time base starts cycles aligned with input nodes.
// - The input image holds a 16-bit status word, and the counter and the latch, each 32 or 16 bits by layout.
// - The output image holds a control word and a counter preset of 32 or 16 bits by layout.
// - Optionally a 32-bit frequency or a 32-bit period result is reported.
// - Optionally a 32-bit or 64-bit time stamp of the last counted increment edge is reported.
// - Time stamp layouts are offered only in a synchronous mode, 32-bit counter with 64-bit stamp or 16 with 32.
// - A layout change applies only after a communication restart, online parameters apply at once.
`ifndef ENC_COUNTER_MAP_SVH
`define ENC_COUNTER_MAP_SVH

`define OFS_CONFIG      12'h000
`define OFS_CONTROL     12'h004
`define OFS_PRESET      12'h008
`define OFS_STATUS      12'h00c
`define OFS_COUNTER     12'h010
`define OFS_LATCH       12'h014
`define OFS_OPTIONAL    12'h018
`define OFS_STAMP_LO    12'h01c
`define OFS_STAMP_HI    12'h020
`define OFS_LAYOUT_ACT  12'h024
`define OFS_CYCLE_TIME  12'h028

`define CFG_GATE_LSB    0
`define CFG_SINGLE      2
`define CFG_RANGE_LONG  3
`define CFG_OPT_FREQ    4
`define CFG_SYNC_LSB    5
`define CFG_LAYOUT_LSB  8

`define CTL_LATCH_EN    0
`define CTL_SET_CNT     2
`define CTL_RESTART     15

`define CYCLE_TIME_RST  32'h00009c40
`define CLK_HZ          40000000
`define PERIOD_UNIT_NS  100
`define UNIT_CYCLES     ((`PERIOD_UNIT_NS * `CLK_HZ) / 1000000000)
`define PERIOD_MAX_S_X10_SHORT 16
`define PERIOD_MAX_S_X10_LONG  32
`define PERIOD_MAX_SHORT (`PERIOD_MAX_S_X10_SHORT * 100000000 / `PERIOD_UNIT_NS)
`define PERIOD_MAX_LONG  (`PERIOD_MAX_S_X10_LONG * 100000000 / `PERIOD_UNIT_NS)

`endif

// [src/enc_counter_pkg.sv]
// Types shared by the encoder counter.
// Assumes the map header supplies all numeric constants.
package enc_counter_pkg;
    typedef enum logic [1:0] {
        GATE_NONE,
        GATE_INHIBIT_HIGH,
        GATE_INHIBIT_LOW,
        GATE_RSVD
    } gate_mode_t;
    typedef enum logic [1:0] {
        FRAME_TRIGGERED_MODE,
        CLOCK_SYNCHRONOUS_MODE,
        INPUT_ALIGNED_SYNCHRONOUS_MODE,
        SYNC_RSVD
    } sync_mode_t;
    typedef enum logic [1:0] {
        STANDARD_DATA_LAYOUT_32,
        STANDARD_DATA_LAYOUT_16,
        LAYOUT_32_STAMP_64,
        LAYOUT_16_STAMP_32
    } layout_t;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic gate;
    } enc_pins_t;
    typedef struct packed {
        logic [15:0] status;
        logic [31:0] counter;
        logic [31:0] latch;
    } in_image_t;
endpackage

// [src/incremental_encoder_counter.sv]
// Incremental encoder counter with quadrature decoder, latch, period meter and AXI4-Lite registers.
// Assumes encoder pins are asynchronous and the frame arrival pulse comes from logic on aclk.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "enc_counter_map.svh"
module incremental_encoder_counter
    import enc_counter_pkg::*;
#(
    parameter int unsigned PERIOD_MAX_SHORT = `PERIOD_MAX_SHORT,
    parameter int unsigned PERIOD_MAX_LONG  = `PERIOD_MAX_LONG,
    parameter int unsigned UNIT_CYCLES      = `UNIT_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire enc_pins_t   enc_pins,
    input  wire logic        frame_arrival,
    input  wire logic [63:0] sys_time,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cycle_start
);

    // Pin synchronisers.
    enc_pins_t  pins_s1_q;
    enc_pins_t  pins_s2_q;
    enc_pins_t  pins_old_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_s1_q  <= '0;
            pins_s2_q  <= '0;
            pins_old_q <= '0;
        end else begin
            pins_s1_q  <= enc_pins;
            pins_s2_q  <= pins_s1_q;
            pins_old_q <= pins_s2_q;
        end
    end

    // Registers.
    logic [31:0] config_q;
    logic [15:0] control_q;
    logic [31:0] preset_q;
    logic [31:0] cycle_time_q;
    layout_t     layout_act_q;
    logic [31:0] counter_q;
    logic [31:0] latch_q;
    logic        latch_flag_q;
    logic [31:0] period_q;
    logic [31:0] unit_cnt_q;
    logic [31:0] ticks_q;
    logic        period_valid_q;
    logic        period_ovf_q;
    logic [63:0] stamp_q;
    logic [31:0] cycle_cnt_q;
    logic        cycle_start_q;

    gate_mode_t  gate_mode;
    sync_mode_t  sync_mode;
    layout_t     layout_req;
    wire         single_mode = config_q[`CFG_SINGLE];
    wire         range_long  = config_q[`CFG_RANGE_LONG];
    wire         opt_freq    = config_q[`CFG_OPT_FREQ];
    wire         is_16       = layout_act_q[0];
    assign gate_mode  = gate_mode_t'(config_q[`CFG_GATE_LSB +: 2]);
    assign sync_mode  = sync_mode_t'(config_q[`CFG_SYNC_LSB +: 2]);
    assign layout_req = layout_t'(config_q[`CFG_LAYOUT_LSB +: 2]);

    // Quadrature and single-channel decode.
    wire a_now  = pins_s2_q.a;
    wire b_now  = pins_s2_q.b;
    wire a_old  = pins_old_q.a;
    wire b_old  = pins_old_q.b;
    wire a_edge = a_now ^ a_old;
    wire b_edge = b_now ^ b_old;
    wire a_rise = a_now & ~a_old;
    wire quad_step = (a_edge ^ b_edge);
    wire quad_up   = a_edge ? (a_now ^ b_now) : ~(a_now ^ b_now);
    wire step      = single_mode ? a_rise : quad_step;
    wire step_up   = single_mode ? b_now : quad_up;
    wire gate_lvl  = pins_s2_q.gate;
    wire inhibit   = (gate_mode == GATE_INHIBIT_HIGH && gate_lvl) ||
                     (gate_mode == GATE_INHIBIT_LOW && !gate_lvl);
    wire gate_rise = gate_lvl & ~pins_old_q.gate;
    wire latch_evt = control_q[`CTL_LATCH_EN] && gate_mode == GATE_NONE && gate_rise;
    wire set_cnt   = control_q[`CTL_SET_CNT];
    wire [31:0] cnt_inc = counter_q + 32'h00000001;
    wire [31:0] cnt_dec = counter_q - 32'h00000001;
    wire [31:0] cnt_step = step_up ? cnt_inc : cnt_dec;
    wire [31:0] cnt_wrap = is_16 ? {16'h0000, cnt_step[15:0]} : cnt_step;
    wire [31:0] preset_w = is_16 ? {16'h0000, preset_q[15:0]} : preset_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_q <= '0;
        end else if (set_cnt) begin
            counter_q <= preset_w;
        end else if (step && !inhibit) begin
            counter_q <= cnt_wrap;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= '0;
        end else if (latch_evt) begin
            latch_q <= counter_q;
        end
    end

    // Period measurement in 100 ns units.
    wire        unit_tick  = (unit_cnt_q == UNIT_CYCLES - 1);
    wire [31:0] period_max = range_long ? PERIOD_MAX_LONG : PERIOD_MAX_SHORT;
    wire        at_max     = (ticks_q >= period_max);
    wire [31:0] ticks_now  = ticks_q + {31'h0, unit_tick};
    wire        now_max    = (ticks_now >= period_max);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_cnt_q <= '0;
        end else if (a_rise || unit_tick) begin
            unit_cnt_q <= '0;
        end else begin
            unit_cnt_q <= unit_cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ticks_q        <= '0;
            period_q       <= '0;
            period_valid_q <= 1'b0;
            period_ovf_q   <= 1'b0;
        end else if (a_rise) begin
            ticks_q        <= '0;
            period_q       <= now_max ? period_max : ticks_now;
            period_valid_q <= 1'b1;
            period_ovf_q   <= now_max;
        end else if (unit_tick && !at_max) begin
            ticks_q <= ticks_q + 32'h00000001;
        end
    end

    // Frequency in millihertz derived from the period.
    wire [31:0] freq_w = (period_q == '0) ? 32'h00000000 : 32'(64'd10000000000 / {32'h0, period_q});

    // Time stamp of the last counted increment edge.
    wire sync_on = (sync_mode == CLOCK_SYNCHRONOUS_MODE) || (sync_mode == INPUT_ALIGNED_SYNCHRONOUS_MODE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stamp_q <= '0;
        end else if (step && step_up && !inhibit && sync_on) begin
            stamp_q <= sys_time;
        end
    end

    // Cycle start: frame arrival or local time base.
    wire cycle_due = (cycle_cnt_q >= cycle_time_q - 32'h00000001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycle_cnt_q   <= '0;
            cycle_start_q <= 1'b0;
        end else if (sync_mode == FRAME_TRIGGERED_MODE || sync_mode == SYNC_RSVD) begin
            cycle_cnt_q   <= '0;
            cycle_start_q <= frame_arrival;
        end else begin
            cycle_cnt_q   <= cycle_due ? '0 : cycle_cnt_q + 32'h00000001;
            cycle_start_q <= cycle_due;
        end
    end
    assign cycle_start = cycle_start_q;

    // Layout takes effect only on a restart, and stamp layouts only when synchronous.
    wire     stamp_req = layout_req[1];
    layout_t layout_ok;
    assign layout_ok = (stamp_req && !sync_on) ? layout_t'({1'b0, layout_req[0]}) : layout_req;
    wire     restart   = control_q[`CTL_RESTART];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            layout_act_q <= STANDARD_DATA_LAYOUT_32;
        end else if (restart) begin
            layout_act_q <= layout_ok;
        end
    end

    // Input image.
    in_image_t img;
    assign img.status  = {12'h000, period_ovf_q, period_valid_q, inhibit, latch_flag_q};
    assign img.counter = is_16 ? {16'h0000, counter_q[15:0]} : counter_q;
    assign img.latch   = is_16 ? {16'h0000, latch_q[15:0]} : latch_q;

    // AXI4-Lite write channel.
    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    wire         aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire         w_take  = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire         wr_go   = aw_held_q && w_held_q;
    wire         wr_cfg  = wr_go && awaddr_q == `OFS_CONFIG;
    wire         wr_ctl  = wr_go && awaddr_q == `OFS_CONTROL;
    wire         wr_pre  = wr_go && awaddr_q == `OFS_PRESET;
    wire         wr_cyc  = wr_go && awaddr_q == `OFS_CYCLE_TIME;
    wire         wr_ok   = wr_cfg || wr_ctl || wr_pre || wr_cyc;
    wire [31:0]  wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Online parameters take effect at once.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q     <= '0;
            control_q    <= '0;
            preset_q     <= '0;
            cycle_time_q <= `CYCLE_TIME_RST;
        end else begin
            if (wr_cfg) config_q <= (config_q & ~wmask) | (wdata_q & wmask);
            if (wr_pre) preset_q <= (preset_q & ~wmask) | (wdata_q & wmask);
            if (wr_cyc) cycle_time_q <= (cycle_time_q & ~wmask) | (wdata_q & wmask);
            if (wr_ctl) begin
                control_q <= (control_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
            end else begin
                control_q[`CTL_SET_CNT] <= 1'b0;
                control_q[`CTL_RESTART] <= 1'b0;
            end
        end
    end

    // Latch flag: set wins over clear by a status read.
    logic       rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire        ar_take = s_axi_arvalid && !rvalid_q;
    wire [11:0] raddr   = {s_axi_araddr[11:2], 2'h0};
    wire        rd_stat = ar_take && raddr == `OFS_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_flag_q <= 1'b0;
        end else if (latch_evt) begin
            latch_flag_q <= 1'b1;
        end else if (rd_stat) begin
            latch_flag_q <= 1'b0;
        end
    end

    // AXI4-Lite read channel.
    wire [31:0] opt_w = opt_freq ? freq_w : period_q;
    wire [31:0] stamp_lo_w = layout_act_q == LAYOUT_16_STAMP_32 || layout_act_q == LAYOUT_32_STAMP_64 ?
                             stamp_q[31:0] : 32'h00000000;
    wire [31:0] stamp_hi_w = layout_act_q == LAYOUT_32_STAMP_64 ? stamp_q[63:32] : 32'h00000000;
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (raddr)
            `OFS_CONFIG:     rd_mux = config_q;
            `OFS_CONTROL:    rd_mux = {16'h0000, control_q};
            `OFS_PRESET:     rd_mux = preset_q;
            `OFS_STATUS:     rd_mux = {16'h0000, img.status};
            `OFS_COUNTER:    rd_mux = img.counter;
            `OFS_LATCH:      rd_mux = img.latch;
            `OFS_OPTIONAL:   rd_mux = opt_w;
            `OFS_STAMP_LO:   rd_mux = stamp_lo_w;
            `OFS_STAMP_HI:   rd_mux = stamp_hi_w;
            `OFS_LAYOUT_ACT: rd_mux = {30'h00000000, layout_act_q};
            `OFS_CYCLE_TIME: rd_mux = cycle_time_q;
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= 2'h0;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_arready = ar_take;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule

// [tb/enc_counter_sva.sv]
// Concurrent checks on the bus and cycle-start ports of the encoder counter.
// Assumes it is bound to the counter's top module and that software writes whole words.
`include "enc_counter_map.svh"
module enc_counter_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        frame_arrival,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cycle_start
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] wa_q, wd_q, ct_q, gap_q;
    logic [1:0]  md_q;
    logic        seen_q;
    wire logic   b_done = s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0;
    wire logic   ro_adr = wa_q[11:0] inside {`OFS_STATUS, `OFS_COUNTER, `OFS_LATCH, `OFS_LAYOUT_ACT};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            md_q   <= 2'h0;
            ct_q   <= `CYCLE_TIME_RST;
            seen_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
            if (b_done && wa_q[11:0] == `OFS_CONFIG) md_q <= wd_q[6:5];
            if (b_done && wa_q[11:0] == `OFS_CYCLE_TIME) ct_q <= wd_q;
            seen_q <= b_done ? 1'b0 : (seen_q || cycle_start);
        end
    end
    always_ff @(posedge aclk) gap_q <= cycle_start ? 32'h1 : gap_q + 32'h1;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    ro_refuse_a: assert property (s_axi_bvalid && ro_adr |-> s_axi_bresp == 2'h2)
        else $error("read-only write accepted");
    frame_start_a: assert property (md_q == 2'h0 && frame_arrival |=> cycle_start)
        else $error("frame did not start a cycle");
    frame_cause_a: assert property (md_q == 2'h0 && !s_axi_bvalid && cycle_start |-> $past(frame_arrival))
        else $error("cycle start without frame");
    sync_period_a: assert property (md_q != 2'h0 && seen_q && !s_axi_bvalid && cycle_start |-> gap_q == ct_q)
        else $error("cycle interval wrong");
    cover property (md_q == 2'h0 && frame_arrival);
    cover property (md_q != 2'h0 && seen_q && cycle_start);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// [tb/enc_partner.sv]
// Behavioural encoder and frame source on the far side of the counter.
// Assumes its tasks are called just after a rising edge of aclk.
module enc_partner
    import enc_counter_pkg::*;
(
    input  wire logic aclk,
    output enc_pins_t pins,
    output logic      frame_arrival
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph;
    initial begin
        pins = '0;
        frame_arrival = 1'b0;
        ph = 2'h0;
    end
    // Moves one quadrature state, A leading B when up, then rests.
    task automatic step(input bit up, input int rest);
        ph = up ? ph + 2'h1 : ph - 2'h1;
        pins.a <= ph[1] ^ ph[0];
        pins.b <= ph[1];
        repeat (rest + 1) @(posedge aclk);
    endtask
    // One pulse on A with B held at the given level.
    task automatic pulse_a(input bit lvl, input int gap);
        pins.b <= lvl;
        pins.a <= 1'b1;
        repeat (gap / 2) @(posedge aclk);
        pins.a <= 1'b0;
        repeat (gap - gap / 2) @(posedge aclk);
        ph = lvl ? 2'h3 : 2'h0;
    endtask
    task automatic gate(input bit lvl);
        pins.gate <= lvl;
        repeat (4) @(posedge aclk);
    endtask
    task automatic frame();
        frame_arrival <= 1'b1;
        @(posedge aclk);
        frame_arrival <= 1'b0;
        repeat (20) @(posedge aclk);
    endtask
endmodule

// [tb/incremental_encoder_counter_test.sv]
// Self-checking bench for the incremental encoder counter.
// Assumes the design files, the partner model and the checker are compiled first.
`include "enc_counter_map.svh"
module incremental_encoder_counter_test import enc_counter_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int UNIT = 4;
    localparam int PMAX_S = 50;
    localparam int PMAX_L = 100;
    localparam int CT = 50;
    logic        aclk;
    logic        aresetn = 1'b0;
    enc_pins_t   enc_pins;
    logic        frame_arrival, cycle_start;
    logic [63:0] sys_time = 64'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rv;
    int          n_errors = 0, n_compared = 0, seed, cnt_m, base, d0, cyc = 0, last_s = 0, gap = 0, n_starts = 0;
    incremental_encoder_counter #(.PERIOD_MAX_SHORT(PMAX_S), .PERIOD_MAX_LONG(PMAX_L), .UNIT_CYCLES(UNIT)) i_dut (.*);
    enc_partner i_enc (.aclk(aclk), .pins(enc_pins), .frame_arrival(frame_arrival));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        sys_time <= sys_time + 64'h1;
        cyc <= cyc + 1;
        if (cycle_start === 1'b1) begin
            gap <= cyc - last_s;
            last_s <= cyc;
            n_starts <= n_starts + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w, b;
        {s_axi_awaddr, s_axi_wdata} <= {20'h0, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge aclk);
            {aw, w, b} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_bvalid};
            rr = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        chk("write response", {30'h0, er}, {30'h0, rr});
    endtask
    task automatic rd(input logic [11:0] a);
        bit ar, r;
        s_axi_araddr <= {20'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(negedge aclk);
            {ar, r} = {s_axi_arvalid && s_axi_arready, s_axi_rvalid};
            {rv, rr} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!r);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
        chk("read response", 32'h0, {30'h0, rr});
    endtask
    task automatic mv(input int n, input bit up, input bit live);
        for (int i = 0; i < n; i++) begin
            cnt_m += live ? (up ? 1 : -1) : 0;
            i_enc.step(up, $unsigned($random(seed)) % 4);
        end
        repeat (4) @(posedge aclk);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        results();
    end
    initial begin
        seed = 32'h6b67;
        cnt_m = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("config", `OFS_CONFIG, 32'h0);
        rc("cycle time", `OFS_CYCLE_TIME, `CYCLE_TIME_RST);
        rc("layout", `OFS_LAYOUT_ACT, 32'h0);
        rc("latch", `OFS_LATCH, 32'h0);
        rd(12'h100);
        chk("unmapped read", 32'h2, {30'h0, rr});
        wr(12'h100, 32'h1, 2'h2);
        wr(`OFS_COUNTER, 32'h5, 2'h2);
        rc("counter", `OFS_COUNTER, 32'h0);
        for (int i = 0; i < 40; i++) mv(1, ($random(seed) & 1) == 1, 1'b1);
        rc("counter", `OFS_COUNTER, 32'(cnt_m));
        wr(`OFS_PRESET, 32'hfffffffe, 2'h0);
        wr(`OFS_CONTROL, 32'h4, 2'h0);
        cnt_m = -2;
        mv(3, 1'b1, 1'b1);
        rc("counter wrap", `OFS_COUNTER, 32'(cnt_m));
        wr(`OFS_CONFIG, 32'h100, 2'h0);
        rc("layout", `OFS_LAYOUT_ACT, 32'h0);
        wr(`OFS_CONTROL, 32'h8000, 2'h0);
        rc("layout", `OFS_LAYOUT_ACT, 32'h1);
        wr(`OFS_PRESET, 32'h0000ffff, 2'h0);
        wr(`OFS_CONTROL, 32'h4, 2'h0);
        cnt_m = 65535;
        mv(2, 1'b1, 1'b1);
        rc("counter short", `OFS_COUNTER, 32'(cnt_m) & 32'hffff);
        wr(`OFS_CONFIG, 32'h0, 2'h0);
        wr(`OFS_CONTROL, 32'h8000, 2'h0);
        cnt_m = $random(seed);
        wr(`OFS_PRESET, 32'(cnt_m), 2'h0);
        wr(`OFS_CONTROL, 32'h4, 2'h0);
        for (int g = 0; g < 3; g++) begin
            for (int l = 0; l < 2; l++) begin
                wr(`OFS_CONFIG, 32'(g), 2'h0);
                i_enc.gate(l[0]);
                mv(3, 1'b1, !((g == 1 && l == 1) || (g == 2 && l == 0)));
                rc("gated counter", `OFS_COUNTER, 32'(cnt_m));
            end
        end
        wr(`OFS_CONFIG, 32'h0, 2'h0);
        wr(`OFS_CONTROL, 32'h1, 2'h0);
        i_enc.gate(1'b0);
        mv(5, 1'b0, 1'b1);
        i_enc.gate(1'b1);
        rc("latch", `OFS_LATCH, 32'(cnt_m));
        wr(`OFS_CONFIG, 32'h4, 2'h0);
        i_enc.pulse_a(1'b0, 8);
        rd(`OFS_COUNTER);
        base = rv;
        repeat (5) i_enc.pulse_a(1'b0, 8);
        rd(`OFS_COUNTER);
        d0 = rv - base;
        repeat (5) i_enc.pulse_a(1'b1, 8);
        rc("single channel", `OFS_COUNTER, 32'(base));
        chk("single steps", 32'hfffffffb, 32'(d0));
        wr(`OFS_CONFIG, 32'h0, 2'h0);
        repeat (3) i_enc.pulse_a(1'b0, 10 * UNIT);
        rc("period", `OFS_OPTIONAL, 32'd10);
        wr(`OFS_CONFIG, 32'h10, 2'h0);
        rc("frequency", `OFS_OPTIONAL, 32'd1000000000);
        for (int r = 0; r < 2; r++) begin
            wr(`OFS_CONFIG, 32'(r) << 3, 2'h0);
            i_enc.pulse_a(1'b0, 300 * UNIT);
            i_enc.pulse_a(1'b0, 8);
            rc("period limit", `OFS_OPTIONAL, 32'(r == 0 ? PMAX_S : PMAX_L));
        end
        wr(`OFS_CONFIG, 32'h200, 2'h0);
        wr(`OFS_CONTROL, 32'h8000, 2'h0);
        rc("layout", `OFS_LAYOUT_ACT, 32'h0);
        base = n_starts;
        repeat (5) i_enc.frame();
        chk("frame starts", 32'd5, 32'(n_starts - base));
        wr(`OFS_CYCLE_TIME, 32'(CT), 2'h0);
        for (int m = 1; m < 3; m++) begin
            wr(`OFS_CONFIG, (32'(m) << 5) | 32'h200, 2'h0);
            wr(`OFS_CONTROL, 32'h8000, 2'h0);
            rc("layout", `OFS_LAYOUT_ACT, 32'h2);
            repeat (4 * CT) @(posedge aclk);
            chk("cycle gap", 32'(CT), 32'(gap));
        end
        results();
    end
endmodule
bind incremental_encoder_counter enc_counter_sva i_sva (.*);
